// ==== logic/iomb_exec.sv ====
// execute core for increment, skip-increment, or, move and branch
`timescale 1ns/100ps
`default_nettype none
module iomb_exec
(
   // clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          rst_n_i,
   // decoded instruction, one per instruction cycle
   input  wire logic                          instr_valid_i,
   input  wire iomb_pkg::iomb_op_t            op_i,
   input  wire logic                          dest_sel_i,
   input  wire logic [iomb_pkg::ADDR_W-1:0]   reg_addr_i,
   input  wire logic [iomb_pkg::LIT_W-1:0]    literal_i,
   input  wire logic [iomb_pkg::TGT_W-1:0]    branch_target_i,
   // file register and address latch contents
   input  wire logic [iomb_pkg::DATA_W-1:0]   reg_rdata_i,
   input  wire logic [iomb_pkg::LATCH_W-1:0]  upper_address_latch_i,
   // results
   output logic [iomb_pkg::DATA_W-1:0]        acc_o,
   output logic                               zero_o,
   output logic                               reg_we_o,
   output logic [iomb_pkg::ADDR_W-1:0]        reg_waddr_o,
   output logic [iomb_pkg::DATA_W-1:0]        reg_wdata_o,
   output logic [iomb_pkg::PC_W-1:0]          pc_o,
   output logic                               pc_load_o,
   output logic                               squash_o,
   output logic                               busy_o
);
   //--------------------------------------------
   // decode and compute
   //--------------------------------------------
   iomb_wb_if wb ();

   logic [iomb_pkg::DATA_W-1:0] acc_ff;
   logic                        zero_ff;
   logic                        reg_we_ff;
   logic [iomb_pkg::DATA_W-1:0] reg_wdata_ff;
   logic [iomb_pkg::ADDR_W-1:0] reg_waddr_ff;
   logic [iomb_pkg::PC_W-1:0]   pc_ff;
   logic                        pc_load_ff;
   logic                        squash_ff;
   logic                        slot_ff;     // second cycle in progress
   logic                        go;
   logic [iomb_pkg::DATA_W-1:0] incr_val;

   // wrap-around increment
   function automatic logic [7:0] incr8(input logic [7:0] v);
      incr8 = v + 8'h01;
   endfunction

   // a new instruction is taken only outside a filled second slot
   assign go       = instr_valid_i && !slot_ff;
   assign incr_val = incr8(reg_rdata_i);

   // result, routing and zero-flag enables per operation
   always_comb
   begin
      wb.result   = 8'h00;
      wb.to_reg   = 1'b0;
      wb.to_acc   = 1'b0;
      wb.set_zero = 1'b0;
      wb.valid    = go;
      unique case (op_i)
         iomb_pkg::IOMB_OP_INCREMENT_SKIP_ZERO:
         begin
            wb.result = incr_val;
            wb.to_reg = dest_sel_i;
            wb.to_acc = !dest_sel_i;
         end
         iomb_pkg::IOMB_OP_OR_LITERAL_ACCUM:
         begin
            wb.result   = acc_ff | literal_i;
            wb.to_acc   = 1'b1;
            wb.set_zero = 1'b1;
         end
         iomb_pkg::IOMB_OP_INCREMENT_REG:
         begin
            wb.result   = incr_val;
            wb.to_reg   = dest_sel_i;
            wb.to_acc   = !dest_sel_i;
            wb.set_zero = 1'b1;
         end
         iomb_pkg::IOMB_OP_OR_ACCUM_REG:
         begin
            wb.result   = acc_ff | reg_rdata_i;
            wb.to_reg   = dest_sel_i;
            wb.to_acc   = !dest_sel_i;
            wb.set_zero = 1'b1;
         end
         iomb_pkg::IOMB_OP_MOVE_REG:
         begin
            wb.result   = reg_rdata_i;
            wb.to_reg   = dest_sel_i;
            wb.to_acc   = !dest_sel_i;
            wb.set_zero = 1'b1;
         end
         // branch leaves data and flags alone
         iomb_pkg::IOMB_OP_UNCONDITIONAL_BRANCH,
         iomb_pkg::IOMB_OP_NONE:
            wb.valid = 1'b0;
         default:
            wb.valid = 1'b0;
      endcase
   end

   //--------------------------------------------
   // result stage
   //--------------------------------------------
   iomb_wb_stage u_wb
   (
      .clk_i        (clk_i),
      .rst_n_i      (rst_n_i),
      .wb           (wb),
      .acc_ff       (acc_ff),
      .zero_ff      (zero_ff),
      .reg_we_ff    (reg_we_ff),
      .reg_wdata_ff (reg_wdata_ff)
   );

   // write address follows the instruction
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         reg_waddr_ff <= '0;
      else if (go)
         reg_waddr_ff <= reg_addr_i;
   end

   //--------------------------------------------
   // program counter load for the branch
   //--------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         pc_ff      <= iomb_pkg::PC_RST;
         pc_load_ff <= 1'b0;
      end
      else
      begin
         pc_load_ff <= go && (op_i == iomb_pkg::IOMB_OP_UNCONDITIONAL_BRANCH);
         if (go && (op_i == iomb_pkg::IOMB_OP_UNCONDITIONAL_BRANCH))
            pc_ff <= {upper_address_latch_i[iomb_pkg::LATCH_HI:iomb_pkg::LATCH_LO],
                      branch_target_i};
      end
   end

   //--------------------------------------------
   // second-cycle slot: branch refill or skip
   //--------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         slot_ff   <= 1'b0;
         squash_ff <= 1'b0;
      end
      else if (slot_ff)
      begin
         slot_ff   <= 1'b0;   // empty slot spent, next fetch resumes
         squash_ff <= 1'b0;
      end
      else if (go && op_i == iomb_pkg::IOMB_OP_UNCONDITIONAL_BRANCH)
      begin
         slot_ff   <= 1'b1;
         squash_ff <= 1'b1;
      end
      else if (go && op_i == iomb_pkg::IOMB_OP_INCREMENT_SKIP_ZERO)
      begin
         slot_ff   <= (incr_val == 8'h00);
         squash_ff <= (incr_val == 8'h00);
      end
      else
      begin
         slot_ff   <= 1'b0;
         squash_ff <= 1'b0;
      end
   end

   // outputs straight from flip-flops
   assign acc_o       = acc_ff;
   assign zero_o      = zero_ff;
   assign reg_we_o    = reg_we_ff;
   assign reg_waddr_o = reg_waddr_ff;
   assign reg_wdata_o = reg_wdata_ff;
   assign pc_o        = pc_ff;
   assign pc_load_o   = pc_load_ff;
   assign squash_o    = squash_ff;
   assign busy_o      = slot_ff;
endmodule // iomb_exec
`default_nettype wire

// ==== logic/iomb_pkg.sv ====
// constants and types for the increment / or / move / branch execute block
package iomb_pkg;
   localparam int DATA_W      = 8;
   localparam int ADDR_W      = 7;
   localparam int LIT_W       = 8;
   localparam int TGT_W       = 11;
   localparam int PC_W        = 13;
   localparam int LATCH_W     = 8;
   localparam int LATCH_LO    = 3;   // latch bits copied into pc upper
   localparam int LATCH_HI    = 4;
   localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
   localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;
   localparam logic              ZERO_RST = 1'b0;

   typedef enum logic [2:0] {
      IOMB_OP_NONE,
      IOMB_OP_INCREMENT_SKIP_ZERO,
      IOMB_OP_UNCONDITIONAL_BRANCH,
      IOMB_OP_OR_LITERAL_ACCUM,
      IOMB_OP_INCREMENT_REG,
      IOMB_OP_OR_ACCUM_REG,
      IOMB_OP_MOVE_REG
   } iomb_op_t;
endpackage

// ==== logic/iomb_wb_if.sv ====
// write-back bundle between the execute core and the result stage
`timescale 1ns/100ps
`default_nettype none
interface iomb_wb_if;
   logic [7:0] result;     // 8-bit operation result
   logic       to_reg;     // result goes to file register
   logic       to_acc;     // result goes to accumulator
   logic       set_zero;   // zero flag to be updated
   logic       valid;      // one-cycle write-back strobe
   modport src (output result, output to_reg, output to_acc, output set_zero, output valid);
   modport dst (input result, input to_reg, input to_acc, input set_zero, input valid);
endinterface
`default_nettype wire

// ==== logic/iomb_wb_stage.sv ====
// result stage: registers accumulator, zero flag and file register write
`timescale 1ns/100ps
`default_nettype none
module iomb_wb_stage
(
   // clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rst_n_i,
   // write-back bundle
   iomb_wb_if.dst                            wb,
   // state outputs
   output logic [iomb_pkg::DATA_W-1:0]       acc_ff,
   output logic                              zero_ff,
   output logic                              reg_we_ff,
   output logic [iomb_pkg::DATA_W-1:0]       reg_wdata_ff
);
   // accumulator update
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         acc_ff <= iomb_pkg::ACC_RST;
      else if (wb.valid && wb.to_acc)
         acc_ff <= wb.result;
   end

   // zero flag, only when set_zero: set on all-zero result, cleared otherwise
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         zero_ff <= iomb_pkg::ZERO_RST;
      else if (wb.valid && wb.set_zero)
         zero_ff <= (wb.result == 8'h00);
   end

   // file register write port, one-cycle strobe
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         reg_we_ff    <= 1'b0;
         reg_wdata_ff <= 8'h00;
      end
      else
      begin
         reg_we_ff    <= wb.valid && wb.to_reg;
         reg_wdata_ff <= wb.result;
      end
   end
endmodule // iomb_wb_stage
`default_nettype wire

// ==== sim/iomb_exec_props.sv ====
// concurrent checks on the execute core ports
`timescale 1ns/100ps
`default_nettype none
module iomb_exec_props
(
   // clock and reset
   input wire logic               clk_i,
   input wire logic               rst_n_i,
   // instruction side
   input wire logic               instr_valid_i,
   input wire iomb_pkg::iomb_op_t op_i,
   input wire logic               dest_sel_i,
   input wire logic [7:0]         literal_i,
   input wire logic [10:0]        branch_target_i,
   input wire logic [7:0]         reg_rdata_i,
   input wire logic [7:0]         upper_address_latch_i,
   // results
   input wire logic [7:0]         acc_o,
   input wire logic               zero_o,
   input wire logic               reg_we_o,
   input wire logic [7:0]         reg_wdata_o,
   input wire logic [12:0]        pc_o,
   input wire logic               pc_load_o,
   input wire logic               squash_o,
   input wire logic               busy_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // taken instruction of each kind except or accumulator with register
   wire tk = instr_valid_i && !busy_o;
   wire sk = tk && op_i == iomb_pkg::IOMB_OP_INCREMENT_SKIP_ZERO;
   wire br = tk && op_i == iomb_pkg::IOMB_OP_UNCONDITIONAL_BRANCH;
   wire ol = tk && op_i == iomb_pkg::IOMB_OP_OR_LITERAL_ACCUM;
   wire ic = tk && op_i == iomb_pkg::IOMB_OP_INCREMENT_REG;
   wire mv = tk && op_i == iomb_pkg::IOMB_OP_MOVE_REG;
   // empty slot followed by normal issue
   sequence s_gap;
      squash_o && busy_o ##1 !busy_o;
   endsequence
   a_skip_zero_gap: assert property (sk && reg_rdata_i == 8'hFF |=>
      $stable(zero_o) ##0 s_gap) else $error("zero skip did not squash");
   a_skip_no_gap: assert property (sk && reg_rdata_i != 8'hFF |=>
      !squash_o && $stable(zero_o)) else $error("nonzero skip misbehaved");
   a_branch_pc_load: assert property (br |=> pc_load_o && pc_o ==
      {$past(upper_address_latch_i[4:3]), $past(branch_target_i)})
      else $error("branch target wrong");
   a_branch_two_cycle: assert property (br |=> $stable(zero_o) ##0 s_gap)
      else $error("branch slot wrong");
   a_or_literal_acc: assert property (ol |=> acc_o ==
      ($past(acc_o) | $past(literal_i)) && zero_o == (acc_o == 8'h00))
      else $error("or literal wrong");
   a_incr_zero_flag: assert property (ic |=> zero_o ==
      ($past(reg_rdata_i) == 8'hFF)) else $error("increment zero wrong");
   a_move_write_back: assert property (mv && dest_sel_i |=>
      reg_we_o && reg_wdata_o == $past(reg_rdata_i)) else $error("move back wrong");
   a_single_cycle: assert property (tk && !br && !sk |=> !busy_o)
      else $error("unexpected busy");
endmodule // iomb_exec_props
bind iomb_exec iomb_exec_props i_props (.clk_i, .rst_n_i, .instr_valid_i, .op_i,
   .dest_sel_i, .literal_i, .branch_target_i, .reg_rdata_i, .upper_address_latch_i,
   .acc_o, .zero_o, .reg_we_o, .reg_wdata_o, .pc_o, .pc_load_o, .squash_o, .busy_o);
`default_nettype wire

// ==== sim/iomb_exec_test.sv ====
// self-checking bench for the execute core
`timescale 1ns/100ps
`default_nettype none
module iomb_exec_test;
   logic               clk_i = 1'b0;
   logic               rst_n_i = 1'b0;
   logic               instr_valid_i = 1'b0;
   iomb_pkg::iomb_op_t op_i = iomb_pkg::IOMB_OP_NONE;
   logic               dest_sel_i = 1'b0;
   logic [6:0]         reg_addr_i = 7'h00;
   logic [7:0]         literal_i = 8'h00;
   logic [10:0]        branch_target_i = 11'h000;
   logic [7:0]         upper_address_latch_i = 8'h00;
   logic [7:0]         reg_rdata_i, acc_o, reg_wdata_o;
   logic               zero_o, reg_we_o, pc_load_o, squash_o, busy_o;
   logic [6:0]         reg_waddr_o;
   logic [12:0]        pc_o;
   int failures = 0;
   int checked = 0;
   int acc, z, pc, sq, pl, we, wa, v;
   int mem [128];
   always #25 clk_i = ~clk_i;
   iomb_exec i_dut (.clk_i, .rst_n_i, .instr_valid_i, .op_i, .dest_sel_i, .reg_addr_i,
      .literal_i, .branch_target_i, .reg_rdata_i, .upper_address_latch_i, .acc_o, .zero_o,
      .reg_we_o, .reg_waddr_o, .reg_wdata_o, .pc_o, .pc_load_o, .squash_o, .busy_o);
   iomb_regfile_model i_mem (.clk_i, .addr_i(reg_addr_i), .rdata_o(reg_rdata_i),
      .we_i(reg_we_o), .waddr_i(reg_waddr_o), .wdata_i(reg_wdata_o));
   task automatic chk(string n, int e, logic [15:0] s);
      checked++;
      if (s !== 16'(e))
      begin
         failures++;
         $display("MISMATCH %s exp %0h got %0h", n, e, s);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // model of one instruction cycle; a busy slot drops its input
   task automatic step;
      int r;
      r = mem[reg_addr_i];
      we = 0;
      pl = 0;
      v = -1;
      if (sq == 1 || !instr_valid_i)
      begin
         sq = 0;
         return;
      end
      case (op_i)
         iomb_pkg::IOMB_OP_INCREMENT_SKIP_ZERO: v = (r + 1) % 256;
         iomb_pkg::IOMB_OP_INCREMENT_REG: v = (r + 1) % 256;
         iomb_pkg::IOMB_OP_OR_ACCUM_REG: v = acc | r;
         iomb_pkg::IOMB_OP_MOVE_REG: v = r;
         iomb_pkg::IOMB_OP_OR_LITERAL_ACCUM:
         begin
            acc = acc | literal_i;
            z = (acc == 0);
         end
         iomb_pkg::IOMB_OP_UNCONDITIONAL_BRANCH:
         begin
            pc = {upper_address_latch_i[4:3], branch_target_i};
            pl = 1;
            sq = 1;
         end
         default: ;
      endcase
      if (v < 0)
         return;
      if (op_i == iomb_pkg::IOMB_OP_INCREMENT_SKIP_ZERO)
         sq = (v == 0);
      else
         z = (v == 0);
      if (dest_sel_i)
      begin
         we = 1;
         wa = reg_addr_i;
         mem[wa] = v;
      end
      else
         acc = v;
   endtask
   // random instruction stream, squashed slots included
   initial
   begin
      void'($urandom(87));
      for (int i = 0; i < 128; i++)
         mem[i] = (i % 4 == 0) ? 255 : i;
      {acc, z, pc, sq} = '0;
      repeat (8) @(posedge clk_i);
      #5 rst_n_i = 1'b1;
      for (int n = 0; n < 600; n++)
      begin
         // mid-run reset: two edges low, then every output but reg_waddr_o and reg_wdata_o back at its reset value
         if (n == 300)
         begin
            rst_n_i = 1'b0;
            repeat (2) @(posedge clk_i);
            #1;
            {acc, z, pc, sq} = '0;
            chk("acc", acc, 16'(acc_o));
            chk("zero", z, 16'(zero_o));
            chk("busy", sq, 16'(busy_o));
            chk("squash", sq, 16'(squash_o));
            chk("pc_load", 0, 16'(pc_load_o));
            chk("pc", pc, 16'(pc_o));
            chk("we", 0, 16'(reg_we_o));
            #4 rst_n_i = 1'b1;
         end
         instr_valid_i = ($urandom % 8) != 0;
         op_i = iomb_pkg::iomb_op_t'(3'($urandom % 7));
         dest_sel_i = 1'($urandom);
         reg_addr_i = 7'($urandom % 16);
         literal_i = ($urandom % 4 == 0) ? 8'h00 : 8'($urandom);
         branch_target_i = 11'($urandom);
         upper_address_latch_i = 8'($urandom);
         @(posedge clk_i);
         #1;
         step();
         chk("acc", acc, 16'(acc_o));
         chk("zero", z, 16'(zero_o));
         chk("busy", sq, 16'(busy_o));
         chk("squash", sq, 16'(squash_o));
         chk("pc_load", pl, 16'(pc_load_o));
         chk("pc", pc, 16'(pc_o));
         chk("we", we, 16'(reg_we_o));
         if (we == 1)
         begin
            chk("wdata", v, 16'(reg_wdata_o));
            chk("waddr", wa, 16'(reg_waddr_o));
         end
         #4;
      end
      tally_and_finish();
   end
endmodule // iomb_exec_test
`default_nettype wire

// ==== sim/iomb_regfile_model.sv ====
// file register memory facing the execute core
`timescale 1ns/100ps
`default_nettype none
module iomb_regfile_model
(
   // clock
   input  wire logic       clk_i,
   // read and write side
   input  wire logic [6:0] addr_i,
   output logic [7:0]      rdata_o,
   input  wire logic       we_i,
   input  wire logic [6:0] waddr_i,
   input  wire logic [7:0] wdata_i
);
   logic [7:0] mem_ff [128];
   // every fourth cell sits one below wrap
   initial
      for (int i = 0; i < 128; i++)
         mem_ff[i] = (i % 4 == 0) ? 8'hFF : 8'(i);
   // a pending write is seen by a read in the same cycle
   assign rdata_o = (we_i && waddr_i == addr_i) ? wdata_i : mem_ff[addr_i];
   always @(posedge clk_i)
      if (we_i)
         mem_ff[waddr_i] <= wdata_i;
endmodule // iomb_regfile_model
`default_nettype wire
